// ---- src/frm_map.svh ----
// Command codes, field layout, reset values and timing counts of the fault retry manager.
// Assumes a 10 MHz core clock and a shared timebase tick that marks 200 us steps.
`ifndef FRM_MAP_SVH
`define FRM_MAP_SVH
`define FRM_CMD_CLEAR_FAULTS 8'h03
`define FRM_CMD_SUMMARY_BYTE 8'h78
`define FRM_CMD_SUMMARY_WORD 8'h79
`define FRM_CMD_VOUT_FLAGS 8'h7A
`define FRM_CMD_IOUT_FLAGS 8'h7B
`define FRM_CMD_INPUT_FLAGS 8'h7C
`define FRM_CMD_TEMP_FLAGS 8'h7D
`define FRM_CMD_CML_FLAGS 8'h7E
`define FRM_CMD_VENDOR_FLAGS 8'h80
`define FRM_CMD_FIRST_FAULT 8'hB6
`define FRM_CMD_VENDOR_STATUS2 8'hB7
`define FRM_CMD_LINE0_PROPAGATE 8'hD2
`define FRM_CMD_LINE1_PROPAGATE 8'hD3
`define FRM_CMD_LINE0_RESPONSE 8'hD5
`define FRM_CMD_LINE1_RESPONSE 8'hD6
`define FRM_CMD_PAD_STATE 8'hE5
`define FRM_CMD_FAMILY_STATUS 8'hEF
`define FRM_CMD_RETRY_LIMIT 8'hF7
`define FRM_CMD_RETRY_DELAY 8'hF8
`define FRM_PAGE_ALL 8'hFF
`define FRM_PAGE_CH1 8'h01
`define FRM_CFG_RESET 8'h00
`define FRM_RETRY_LIMIT_RESET 3'h0
`define FRM_RETRY_DELAY_RESET 16'h0000
`define FRM_RETRY_NONE 3'h0
`define FRM_RETRY_INFINITE 3'h7
`define FRM_CLK_PERIOD_NS 100
`define FRM_LINE_QUAL_NS 10000
`define FRM_LINE_QUAL_CYCLES ((`FRM_LINE_QUAL_NS + `FRM_CLK_PERIOD_NS - 1) / `FRM_CLK_PERIOD_NS)
`define FRM_QUIET_S 16
`define FRM_QUIET_CYCLES (`FRM_QUIET_S * (1000000000 / `FRM_CLK_PERIOD_NS))
`define FRM_RETRY_CAP_US 13100000
`define FRM_TIMEBASE_US 200
`define FRM_RETRY_CAP_TICKS (`FRM_RETRY_CAP_US / `FRM_TIMEBASE_US)
`define FRM_FLAG_LINE0 0
`define FRM_FLAG_LINE1 1
`endif

// ---- src/frm_pkg.sv ----
// Types of the fault retry manager: channel states and the block's state record.
// Assumes frm_map.svh for all numbers.
package frm_pkg;
   typedef enum logic [4:0] {
      FRM_CH_OFF = 5'h01,
      FRM_CH_ON = 5'h02,
      FRM_CH_FAULT = 5'h04,
      FRM_CH_RETRY = 5'h08,
      FRM_CH_LINE = 5'h10
   } frm_ch_state_t;

   typedef struct packed {
      frm_ch_state_t [1:0] ch_state;
      logic [1:0][2:0] retry_count;
      logic [1:0][2:0] limit_active;
      logic [1:0][27:0] quiet_cnt;
      logic [1:0][15:0] delay_cnt;
      logic [1:0] enable_q;
      logic [1:0][7:0] line_low_cnt;
      logic [2:0] retry_limit;
      logic [15:0] retry_delay;
      logic [1:0] prop0;
      logic [1:0] prop1;
      logic [1:0] resp0;
      logic [1:0] resp1;
      logic [1:0][1:0] vendor_flags;
      logic alert_pend;
      logic line0_oe;
      logic line1_oe;
      logic alert_oe;
      logic [1:0] run;
      logic [15:0] rdata;
      logic rvalid;
   } frm_state_t;
endpackage

// ---- src/frm_top.sv ----
// Fault retry and shared fault line manager for two channels, with its status command codes.
// Assumes a decoded command port from the serial front end, synchronous pins and a
// shared timebase tick; open-drain lines are resolved outside from the enables.
`include "frm_map.svh"

module frm_top #(
   parameter int unsigned QUIET_CLEAR_CYCLES = `FRM_QUIET_CYCLES
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic [7:0] page_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   input wire logic [1:0] ch_enable_i,
   input wire logic [1:0] ch_fault_i,
   input wire logic [1:0] ch_retry_nz_i,
   input wire logic share_tick_i,
   input wire logic line0_i,
   input wire logic line1_i,
   output logic line0_o,
   output logic line0_oe_o,
   output logic line1_o,
   output logic line1_oe_o,
   output logic alert_o,
   output logic alert_oe_o,
   output logic [1:0] ch_run_o,
   input wire logic [1:0][7:0] status_vout_i,
   input wire logic [1:0][7:0] status_iout_i,
   input wire logic [1:0][7:0] status_temp_i,
   input wire logic [7:0] status_input_i,
   input wire logic [7:0] status_cml_i,
   input wire logic [1:0] power_not_good_i,
   input wire logic [15:0] first_fault_i,
   input wire logic [1:0][15:0] vendor_status2_i,
   input wire logic [7:0] family_status_i,
   input wire logic [15:0] pads_i
);
   localparam logic [27:0] QUIET_LAST = 28'(QUIET_CLEAR_CYCLES - 1);
   localparam logic [7:0] LINE_QUAL = 8'(`FRM_LINE_QUAL_CYCLES);
   localparam logic [15:0] RETRY_CAP = 16'(`FRM_RETRY_CAP_TICKS);

   frm_pkg::frm_state_t st;
   frm_pkg::frm_state_t next_st;

   // Page 0xFF addresses both channels at once
   function automatic logic page_hits(input logic [7:0] page, input int unsigned ch);
      page_hits = (page == `FRM_PAGE_ALL) || (page == 8'(ch));
   endfunction

   function automatic logic faulted_off(input frm_pkg::frm_ch_state_t s);
      faulted_off = (s == frm_pkg::FRM_CH_FAULT) || (s == frm_pkg::FRM_CH_RETRY);
   endfunction

   logic [1:0] line_low;
   logic [1:0] line_qual;
   logic [1:0] shut_req;
   logic [1:0] line_hold;
   logic wr;
   logic rd;
   logic clr;
   logic rch;
   logic [15:0] eff_delay;
   logic [7:0] summ_byte;
   logic [15:0] summ_word;

   always_comb begin
      next_st = st;
      line_low = {~line1_i, ~line0_i};
      line_qual = 2'b00;
      shut_req = 2'b00;
      line_hold = 2'b00;
      wr = cmd_valid_i && cmd_write_i;
      rd = cmd_valid_i && !cmd_write_i;
      clr = wr && (cmd_code_i == `FRM_CMD_CLEAR_FAULTS);
      rch = (page_i == `FRM_PAGE_CH1);
      // Internal limiting only; the stored value is what reads back
      eff_delay = (st.retry_delay > RETRY_CAP) ? RETRY_CAP : st.retry_delay;
      summ_byte = 8'h00;
      summ_word = 16'h0000;

      // Counter restarts on any high sample, so short glitches never accumulate
      for (int l = 0; l < 2; l++) begin
         if (!line_low[l]) begin
            next_st.line_low_cnt[l] = 8'h00;
         end else if (st.line_low_cnt[l] != LINE_QUAL) begin
            next_st.line_low_cnt[l] = st.line_low_cnt[l] + 8'h01;
         end
         line_qual[l] = line_low[l] && (st.line_low_cnt[l] == LINE_QUAL);
      end

      // Clear comes first so a shutdown in the same cycle still sets the alert
      if (clr) begin
         next_st.alert_pend = 1'b0;
      end

      for (int c = 0; c < 2; c++) begin
         // A zero response bit keeps the line out of this channel entirely
         shut_req[c] = (line_qual[0] && st.resp0[c]) || (line_qual[1] && st.resp1[c]);
         line_hold[c] = (line_low[0] && st.resp0[c]) || (line_low[1] && st.resp1[c]);
         next_st.enable_q[c] = ch_enable_i[c];

         if (clr && page_hits(page_i, c)) begin
            next_st.vendor_flags[c] = 2'b00;
         end

         if (faulted_off(st.ch_state[c])) begin
            next_st.quiet_cnt[c] = 28'h0000000;
         end else if (st.quiet_cnt[c] == QUIET_LAST) begin
            next_st.retry_count[c] = `FRM_RETRY_NONE;
         end else begin
            next_st.quiet_cnt[c] = st.quiet_cnt[c] + 28'h0000001;
         end

         case (st.ch_state[c])
            frm_pkg::FRM_CH_OFF: begin
               if (ch_enable_i[c]) begin
                  next_st.ch_state[c] = frm_pkg::FRM_CH_ON;
                  next_st.retry_count[c] = `FRM_RETRY_NONE;
                  next_st.limit_active[c] = st.retry_limit;
               end
            end
            frm_pkg::FRM_CH_ON: begin
               if (!ch_enable_i[c]) begin
                  next_st.ch_state[c] = frm_pkg::FRM_CH_OFF;
               end else if (ch_fault_i[c]) begin
                  // Shared limit, unlimited at 7, count never passes the limit
                  if (ch_retry_nz_i[c] && ((st.limit_active[c] == `FRM_RETRY_INFINITE) ||
                        (st.retry_count[c] < st.limit_active[c]))) begin
                     next_st.ch_state[c] = frm_pkg::FRM_CH_RETRY;
                     next_st.delay_cnt[c] = 16'h0000;
                     if (st.limit_active[c] != `FRM_RETRY_INFINITE) begin
                        next_st.retry_count[c] = st.retry_count[c] + 3'h1;
                     end
                  end else begin
                     next_st.ch_state[c] = frm_pkg::FRM_CH_FAULT;
                  end
               end else if (shut_req[c]) begin
                  next_st.ch_state[c] = frm_pkg::FRM_CH_LINE;
                  next_st.vendor_flags[c][l_flag(st.resp0[c], line_qual[0])] = 1'b1;
                  next_st.alert_pend = 1'b1;
               end
            end
            frm_pkg::FRM_CH_RETRY: begin
               if (!ch_enable_i[c]) begin
                  next_st.ch_state[c] = frm_pkg::FRM_CH_OFF;
               end else if (share_tick_i) begin
                  // Interval is counted only in timebase steps
                  if (st.delay_cnt[c] >= eff_delay) begin
                     next_st.ch_state[c] = frm_pkg::FRM_CH_ON;
                  end else begin
                     next_st.delay_cnt[c] = st.delay_cnt[c] + 16'h0001;
                  end
               end
            end
            frm_pkg::FRM_CH_FAULT: begin
               // Latched off; clearing status does not restart it
               if (!ch_enable_i[c]) begin
                  next_st.ch_state[c] = frm_pkg::FRM_CH_OFF;
               end
            end
            frm_pkg::FRM_CH_LINE: begin
               if (!ch_enable_i[c]) begin
                  next_st.ch_state[c] = frm_pkg::FRM_CH_OFF;
               end else if (!line_hold[c]) begin
                  // Turn-on delay and rise time are applied by the sequencer on run
                  next_st.ch_state[c] = frm_pkg::FRM_CH_ON;
               end
            end
            default: begin
               next_st.ch_state[c] = frm_pkg::FRM_CH_OFF;
            end
         endcase
         next_st.run[c] = (next_st.ch_state[c] == frm_pkg::FRM_CH_ON);
      end

      next_st.line0_oe = (faulted_off(next_st.ch_state[0]) && st.prop0[0]) ||
         (faulted_off(next_st.ch_state[1]) && st.prop0[1]);
      next_st.line1_oe = (faulted_off(next_st.ch_state[0]) && st.prop1[0]) ||
         (faulted_off(next_st.ch_state[1]) && st.prop1[1]);
      next_st.alert_oe = next_st.alert_pend;

      if (wr) begin
         for (int c = 0; c < 2; c++) begin
            if (page_hits(page_i, c)) begin
               if (cmd_code_i == `FRM_CMD_LINE0_PROPAGATE) begin
                  next_st.prop0[c] = cmd_wdata_i[0];
               end
               if (cmd_code_i == `FRM_CMD_LINE1_PROPAGATE) begin
                  next_st.prop1[c] = cmd_wdata_i[0];
               end
            end
         end
         case (cmd_code_i)
            `FRM_CMD_LINE0_RESPONSE: next_st.resp0 = cmd_wdata_i[1:0];
            `FRM_CMD_LINE1_RESPONSE: next_st.resp1 = cmd_wdata_i[1:0];
            `FRM_CMD_RETRY_LIMIT: next_st.retry_limit = cmd_wdata_i[2:0];
            `FRM_CMD_RETRY_DELAY: next_st.retry_delay = cmd_wdata_i;
            default: begin
            end
         endcase
      end

      summ_byte = {1'b0, !st.run[rch], status_vout_i[rch][7], 1'b0, status_input_i[4],
         |status_temp_i[rch], |status_cml_i, 1'b0};
      summ_word = {|status_vout_i[rch], |status_iout_i[rch], |status_input_i,
         |st.vendor_flags[rch], power_not_good_i[rch], 3'h0, summ_byte};
      summ_word[0] = |summ_word[15:8];
      summ_byte[0] = summ_word[0];

      next_st.rvalid = rd;
      if (rd) begin
         case (cmd_code_i)
            `FRM_CMD_SUMMARY_BYTE: next_st.rdata = {8'h00, summ_byte};
            `FRM_CMD_SUMMARY_WORD: next_st.rdata = summ_word;
            `FRM_CMD_VOUT_FLAGS: next_st.rdata = {8'h00, status_vout_i[rch]};
            `FRM_CMD_IOUT_FLAGS: next_st.rdata = {8'h00, status_iout_i[rch]};
            `FRM_CMD_INPUT_FLAGS: next_st.rdata = {8'h00, status_input_i};
            `FRM_CMD_TEMP_FLAGS: next_st.rdata = {8'h00, status_temp_i[rch]};
            `FRM_CMD_CML_FLAGS: next_st.rdata = {8'h00, status_cml_i};
            `FRM_CMD_VENDOR_FLAGS: next_st.rdata = {14'h0000, st.vendor_flags[rch]};
            `FRM_CMD_FIRST_FAULT: next_st.rdata = first_fault_i;
            `FRM_CMD_VENDOR_STATUS2: next_st.rdata = vendor_status2_i[rch];
            `FRM_CMD_LINE0_PROPAGATE: next_st.rdata = {15'h0000, st.prop0[rch]};
            `FRM_CMD_LINE1_PROPAGATE: next_st.rdata = {15'h0000, st.prop1[rch]};
            `FRM_CMD_LINE0_RESPONSE: next_st.rdata = {14'h0000, st.resp0};
            `FRM_CMD_LINE1_RESPONSE: next_st.rdata = {14'h0000, st.resp1};
            `FRM_CMD_PAD_STATE: next_st.rdata = pads_i;
            `FRM_CMD_FAMILY_STATUS: next_st.rdata = {8'h00, family_status_i};
            `FRM_CMD_RETRY_LIMIT: next_st.rdata = {13'h0000, st.retry_limit};
            `FRM_CMD_RETRY_DELAY: next_st.rdata = st.retry_delay;
            default: next_st.rdata = 16'h0000;
         endcase
      end
   end

   // Which line caused the shutdown; line 0 is reported when both qualify
   function automatic int unsigned l_flag(input logic resp0_bit, input logic qual0);
      l_flag = (resp0_bit && qual0) ? `FRM_FLAG_LINE0 : `FRM_FLAG_LINE1;
   endfunction

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st <= '0;
         for (int c = 0; c < 2; c++) begin
            st.ch_state[c] <= frm_pkg::FRM_CH_OFF;
         end
         st.retry_limit <= `FRM_RETRY_LIMIT_RESET;
         st.retry_delay <= `FRM_RETRY_DELAY_RESET;
         st.resp0 <= 2'(`FRM_CFG_RESET);
         st.resp1 <= 2'(`FRM_CFG_RESET);
         st.prop0 <= 2'(`FRM_CFG_RESET);
         st.prop1 <= 2'(`FRM_CFG_RESET);
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign rvalid_o = st.rvalid;
   assign line0_o = 1'b0;
   assign line1_o = 1'b0;
   assign line0_oe_o = st.line0_oe;
   assign line1_oe_o = st.line1_oe;
   assign alert_o = 1'b0;
   assign alert_oe_o = st.alert_oe;
   assign ch_run_o = st.run;
endmodule

// ---- tb/frm_checker.sv ----
// Port checks of the fault retry manager.
// Assumes one clock and a synchronous active-low reset.
module frm_checker #(
   parameter int unsigned QUIET_CLEAR_CYCLES = 200
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic [1:0] ch_enable_i,
   input wire logic [1:0] ch_fault_i,
   input wire logic line0_i,
   input wire logic line1_i,
   input wire logic line0_o,
   input wire logic line0_oe_o,
   input wire logic line1_o,
   input wire logic alert_o,
   input wire logic alert_oe_o,
   input wire logic [1:0] ch_run_o
);
   logic [7:0] low0;
   logic [7:0] low1;
   logic rd_req;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   assign rd_req = cmd_valid_i && !cmd_write_i;
   // Low run lengths, with margin under the 100 cycle qualification
   always_ff @(posedge clk_i) begin
      low0 <= (line0_i || !resetn_i) ? 8'h00 : low0 + {7'h00, low0 != 8'hFF};
      low1 <= (line1_i || !resetn_i) ? 8'h00 : low1 + {7'h00, low1 != 8'hFF};
   end
   a_read_answer: assert property (rd_req |=> rvalid_o) else $error("read unanswered");
   a_answer_cause: assert property (rvalid_o |-> $past(rd_req)) else $error("stray rvalid");
   a_rdata_holds: assert property (!rvalid_o |-> $stable(rdata_o)) else $error("rdata moved");
   a_resp_upper_zero: assert property (rd_req && cmd_code_i inside {8'hD5, 8'hD6}
      |=> rdata_o[15:2] == 14'h0000) else $error("response upper bits set");
   a_prop_upper_zero: assert property (rd_req && cmd_code_i inside {8'hD2, 8'hD3}
      |=> rdata_o[15:1] == 15'h0000) else $error("propagate upper bits set");
   a_fault_stops_run: assert property (ch_run_o[0] && ch_fault_i[0] |-> ##[1:2] !ch_run_o[0])
      else $error("fault left channel on");
   a_enable_off_run: assert property (!ch_enable_i[1] |-> ##[1:2] !ch_run_o[1])
      else $error("disabled channel runs");
   a_line_no_early: assert property (ch_run_o[0] && ch_enable_i[0] && !ch_fault_i[0]
      && low0 < 8'd90 && low1 < 8'd90 |=> ch_run_o[0]) else $error("early line shutdown");
   a_line_oe_off: assert property (line0_oe_o && $past(line0_oe_o) |-> ch_run_o != 2'b11)
      else $error("line pulled with channels on");
   a_open_drain_zero: assert property (!line0_o && !line1_o && !alert_o)
      else $error("open drain data high");
   c_read: cover property (rd_req ##1 rvalid_o);
   c_line_shut: cover property (low0 > 8'd100 && !ch_run_o[0] && alert_oe_o);
   c_fault_off: cover property (ch_fault_i[0] && ch_run_o[0] ##2 line0_oe_o);
endmodule

bind frm_top frm_checker #(.QUIET_CLEAR_CYCLES(QUIET_CLEAR_CYCLES)) u_frm_checker (
   .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
   .cmd_code_i(cmd_code_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .ch_enable_i(ch_enable_i),
   .ch_fault_i(ch_fault_i), .line0_i(line0_i), .line1_i(line1_i), .line0_o(line0_o),
   .line0_oe_o(line0_oe_o), .line1_o(line1_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o),
   .ch_run_o(ch_run_o));

// ---- tb/frm_peer_model.sv ----
// Peer power manager on both shared fault lines, with the lines' pull-ups.
// Assumes each enable is high while its owner pulls the line low.
module frm_peer_model (
   input wire logic dev0_oe_i,
   input wire logic dev1_oe_i,
   input wire logic [1:0] pull_i,
   output logic line0_o,
   output logic line1_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released lines go to the pull-up level, never to the last value
   assign line0_o = !(dev0_oe_i || pull_i[0]);
   assign line1_o = !(dev1_oe_i || pull_i[1]);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench of the fault retry manager, acting as host and sequencer.
// Assumes a shortened quiet-clear count and a retry delay of zero ticks.
`include "frm_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned QUIET = 200;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   logic cmd_write_i = 1'b0;
   logic [7:0] cmd_code_i = 8'h00;
   logic [15:0] cmd_wdata_i = 16'h0000;
   logic [7:0] page_i = 8'h00;
   logic [1:0] ch_enable_i = 2'h0;
   logic [1:0] ch_fault_i = 2'h0;
   logic [1:0] ch_retry_nz_i = 2'h0;
   logic share_tick_i = 1'b0;
   logic [1:0] pull = 2'h0;
   logic [1:0][7:0] vout = 16'h8000;
   logic [7:0] st_in = 8'h5A;
   logic [7:0] st_cml = 8'hC3;
   logic [15:0] pads = 16'hA55A;
   logic [15:0] first = 16'h1234;
   logic [7:0] family = 8'h69;
   logic [7:0] rd_codes [5] = '{8'h7C, 8'h7E, 8'hE5, 8'hB6, 8'hEF};
   logic [15:0] rd_exp [5] = '{16'h005A, 16'h00C3, 16'hA55A, 16'h1234, 16'h0069};
   logic [15:0] rdata_o;
   logic rvalid_o, line0_i, line1_i, line0_oe_o, line1_oe_o, alert_oe_o;
   logic [1:0] ch_run_o;
   int failures = 0;
   int tests_run = 0;

   always #50 clk_i = ~clk_i;

   frm_top #(.QUIET_CLEAR_CYCLES(QUIET)) u_frm_top (.clk_i(clk_i), .resetn_i(resetn_i),
      .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
      .cmd_wdata_i(cmd_wdata_i), .page_i(page_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .ch_enable_i(ch_enable_i), .ch_fault_i(ch_fault_i), .ch_retry_nz_i(ch_retry_nz_i),
      .share_tick_i(share_tick_i), .line0_i(line0_i), .line1_i(line1_i), .line0_o(),
      .line0_oe_o(line0_oe_o), .line1_o(), .line1_oe_o(line1_oe_o), .alert_o(),
      .alert_oe_o(alert_oe_o), .ch_run_o(ch_run_o), .status_vout_i(vout),
      .status_iout_i(16'h0000), .status_temp_i(16'h0000), .status_input_i(st_in),
      .status_cml_i(st_cml), .power_not_good_i(2'h0), .first_fault_i(first),
      .vendor_status2_i(32'h0), .family_status_i(family), .pads_i(pads));

   frm_peer_model u_frm_peer_model (.dev0_oe_i(line0_oe_o), .dev1_oe_i(line1_oe_o),
      .pull_i(pull), .line0_o(line0_i), .line1_o(line1_i));

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] data);
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_write_i <= wr;
      cmd_code_i <= code;
      cmd_wdata_i <= data;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] code, input logic [15:0] mask, input logic [15:0] exp);
      cmd(1'b0, code, 16'h0000);
      chk({15'h0000, rvalid_o}, 16'h0001);
      chk(rdata_o & mask, exp);
   endtask

   // Each stimulus step settles a few edges so registered outputs have landed
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic fault(input int ch, input logic nz);
      @(posedge clk_i);
      ch_fault_i[ch] <= 1'b1;
      ch_retry_nz_i[ch] <= nz;
      @(posedge clk_i);
      ch_fault_i[ch] <= 1'b0;
      step(3);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_i);
         share_tick_i <= 1'b1;
         @(posedge clk_i);
         share_tick_i <= 1'b0;
      end
      step(3);
   endtask

   task automatic enab(input logic [1:0] en);
      @(posedge clk_i);
      ch_enable_i <= en;
      step(4);
   endtask

   task automatic hold(input logic [1:0] lines, input int n);
      @(posedge clk_i);
      pull <= lines;
      step(n);
   endtask

   task automatic setpage(input logic [7:0] p);
      @(posedge clk_i);
      page_i <= p;
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 4; i++) rd(8'hD2 + 8'(i + i / 2), 16'hFFFF, 16'h0000);
      cmd(1'b1, `FRM_CMD_LINE0_RESPONSE, 16'hFFFF);
      rd(`FRM_CMD_LINE0_RESPONSE, 16'hFFFF, 16'h0003);
      cmd(1'b1, `FRM_CMD_LINE0_PROPAGATE, 16'h0001);
      setpage(`FRM_PAGE_CH1);
      rd(`FRM_CMD_LINE0_PROPAGATE, 16'hFFFF, 16'h0000);
      rd(`FRM_CMD_LINE0_RESPONSE, 16'hFFFF, 16'h0003);
      cmd(1'b1, `FRM_CMD_LINE0_RESPONSE, 16'h0000);
      setpage(8'h00);
      rd(`FRM_CMD_LINE0_PROPAGATE, 16'hFFFF, 16'h0001);
      cmd(1'b1, `FRM_CMD_RETRY_LIMIT, 16'h00F9);
      rd(`FRM_CMD_RETRY_LIMIT, 16'hFFFF, 16'h0001);
      cmd(1'b1, `FRM_CMD_RETRY_DELAY, 16'hFFFF);
      rd(`FRM_CMD_RETRY_DELAY, 16'hFFFF, 16'hFFFF);
      cmd(1'b1, `FRM_CMD_RETRY_DELAY, 16'h0000);
      $display("test config done");
      enab(2'h3);
      chk({14'h0, ch_run_o}, 16'h0003);
      fault(0, 1'b1);
      chk({13'h0, line1_oe_o, line0_oe_o, ch_run_o[0]}, 16'h0002);
      tick(1);
      chk({13'h0, line1_oe_o, line0_oe_o, ch_run_o[0]}, 16'h0001);
      step(QUIET + 50);
      fault(0, 1'b1);
      tick(1);
      chk({15'h0, ch_run_o[0]}, 16'h0001);
      fault(0, 1'b1);
      tick(3);
      chk({15'h0, ch_run_o[0]}, 16'h0000);
      enab(2'h2);
      enab(2'h3);
      cmd(1'b1, `FRM_CMD_RETRY_LIMIT, 16'h0000);
      fault(0, 1'b1);
      tick(1);
      chk({15'h0, ch_run_o[0]}, 16'h0001);
      fault(1, 1'b0);
      enab(2'h2);
      enab(2'h3);
      fault(0, 1'b1);
      tick(2);
      chk({14'h0, ch_run_o}, 16'h0000);
      cmd(1'b1, `FRM_CMD_RETRY_LIMIT, 16'h0007);
      enab(2'h0);
      enab(2'h3);
      for (int i = 0; i < 8; i++) begin
         fault(0, 1'b1);
         tick(1);
         chk({15'h0, ch_run_o[0]}, 16'h0001);
      end
      $display("test retry done");
      cmd(1'b1, `FRM_CMD_LINE0_RESPONSE, 16'h0001);
      cmd(1'b1, `FRM_CMD_LINE1_RESPONSE, 16'h0002);
      hold(2'h1, 60);
      chk({14'h0, ch_run_o}, 16'h0003);
      hold(2'h0, 5);
      hold(2'h1, 150);
      chk({12'h0, alert_oe_o, line0_oe_o, ch_run_o}, 16'h000A);
      rd(`FRM_CMD_VENDOR_FLAGS, 16'hFFFF, 16'h0001);
      hold(2'h0, 5);
      chk({14'h0, ch_run_o}, 16'h0003);
      cmd(1'b1, `FRM_CMD_CLEAR_FAULTS, 16'h0000);
      chk({15'h0, alert_oe_o}, 16'h0000);
      rd(`FRM_CMD_VENDOR_FLAGS, 16'hFFFF, 16'h0000);
      setpage(`FRM_PAGE_CH1);
      hold(2'h2, 150);
      chk({14'h0, ch_run_o}, 16'h0001);
      rd(`FRM_CMD_VENDOR_FLAGS, 16'hFFFF, 16'h0002);
      hold(2'h0, 5);
      cmd(1'b1, `FRM_CMD_LINE1_PROPAGATE, 16'h0001);
      fault(1, 1'b0);
      chk({13'h0, line1_oe_o, line0_oe_o, ch_run_o[1]}, 16'h0004);
      $display("test lines done");
      cmd(1'b1, `FRM_CMD_PAD_STATE, 16'h0000);
      for (int i = 0; i < 5; i++) rd(rd_codes[i], 16'hFFFF, rd_exp[i]);
      rd(`FRM_CMD_VOUT_FLAGS, 16'hFFFF, 16'h0080);
      rd(`FRM_CMD_SUMMARY_WORD, 16'h8020, 16'h8020);
      $display("test status done");
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      summarize();
   end
endmodule
